//--- verilog/hfp_pkg.sv
// constants, types and decode helpers for the host fifo port
package hfp_pkg;

  // register map, byte addresses on the apb bus
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_RXDATA  = 12'h008;
  localparam logic [11:0] ADDR_TXDATA  = 12'h00c;

  // field positions
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_STAT_EN    = 2;
  localparam int ST_MODE_LSB     = 0;
  localparam int ST_RX_VALID     = 2;
  localparam int ST_TX_VALID     = 3;
  localparam int ST_WIDTH_LSB    = 4;
  localparam int ST_SER_LSB      = 6;
  localparam int ST_CMD_LSB      = 8;
  localparam int BYTE_W          = 8;

  typedef enum logic [1:0] {
    MODE_ASYNC  = 2'h0,
    MODE_SYNC   = 2'h1,
    MODE_SERIAL = 2'h2,
    MODE_OFF    = 2'h3
  } hfp_mode_type;

  typedef enum logic [1:0] {
    WIDTH_1 = 2'h0,
    WIDTH_2 = 2'h1,
    WIDTH_4 = 2'h2,
    WIDTH_8 = 2'h3
  } hfp_width_type;

  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_CMD  = 2'h1,
    SER_TURN = 2'h2,
    SER_DATA = 2'h3
  } hfp_ser_type;

  // reset values
  localparam hfp_mode_type CTRL_MODE_RESET = MODE_ASYNC;
  localparam logic         STAT_EN_RESET   = 1'b1;

  // serial command codes and answer levels
  localparam logic [3:0] CMD_WRITE  = 4'h0;
  localparam logic [3:0] CMD_READ   = 4'h1;
  localparam logic       ACK_LEVEL  = 1'b0;
  localparam logic       NAK_LEVEL  = 1'b1;
  localparam logic [2:0] CMD_LAST_BIT = 3'h6;

  // interface clock timing, picoseconds
  localparam int FCLK_PERIOD_PS = 16670;
  localparam int PCLK_PERIOD_PS = 20000;
  localparam int SYNC_STAGES    = 2;
  localparam int FCLK_HALF_RAW  = (FCLK_PERIOD_PS / 2) / PCLK_PERIOD_PS;
  // half period must outlast the input synchronisers
  localparam int FCLK_HALF_CYC  = (FCLK_HALF_RAW > SYNC_STAGES) ?
                                  FCLK_HALF_RAW : SYNC_STAGES + 1;

  // pins sampled from outside the pclk domain
  typedef struct packed {
    logic       rd_n;
    logic       wr_n;
    logic       oe_n;
    logic       ss_low;
    logic       sclk;
    logic [1:0] nv_mode;
    logic [7:0] data;
  } hfp_pins_type;

  // width by priority, unused lines read high
  function automatic hfp_width_type decode_width(input logic [7:0] b);
    if (~&b[7:4])
      return WIDTH_8;
    else if (~&b[3:2])
      return WIDTH_4;
    else if (!b[1])
      return WIDTH_2;
    else
      return WIDTH_1;
  endfunction

  // command code, most significant bit taken from line 0
  function automatic logic [3:0] decode_cmd(input logic [7:0] b);
    return {b[0], b[3], b[5], b[6]};
  endfunction

  function automatic logic [7:0] width_mask(input hfp_width_type w);
    return 8'hff >> (4'h8 - (4'h1 << w));
  endfunction

endpackage

//--- verilog/hfp_sync.sv
// two-stage synchroniser for a bundle of pins
`timescale 1ns/100ps
`default_nettype none
module hfp_sync
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins and synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import hfp_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hfp_sync_type;

  hfp_sync_type s;
  hfp_sync_type next_s;

  always_comb
  begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  // idle-high reset matches pulled-up lines
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '1;
    else
      s <= next_s;
  end

  assign q = s.s2;
endmodule
`default_nettype wire

//--- verilog/hfp_clkdiv.sv
// divider making the fifo interface clock and its rising-edge pulse
`timescale 1ns/100ps
`default_nettype none
module hfp_clkdiv
#(
  parameter int HALF = 3
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control and outputs
  input  wire logic run,
  output logic      clk_out,
  output logic      rise
);
  import hfp_pkg::*;

  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          clk;
    logic          rise;
  } hfp_div_type;

  hfp_div_type s;
  hfp_div_type next_s;

  always_comb
  begin
    next_s      = s;
    next_s.rise = 1'b0;
    if (!run)
    begin
      next_s.cnt = '0;
      next_s.clk = 1'b0;
    end
    else if (s.cnt == LAST)
    begin
      next_s.cnt  = '0;
      next_s.clk  = ~s.clk;
      next_s.rise = ~s.clk;
    end
    else
      next_s.cnt = s.cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign clk_out = s.clk;
  assign rise    = s.rise;
endmodule
`default_nettype wire

//--- verilog/hfp_host_port.sv
// host-facing byte port: sync fifo, async fifo and serial slave modes
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - sync fifo: read and write never overlap; writes ignored while bus turned
// - sync fifo: everything sampled and launched on interface clock rise
// - sync fifo: interface clock driven continuously
// - sync fifo allowed only when strap selects async fifo; the code also allows it when strap selects sync fifo
// - rx_data_avail_n low announces data for the host
// - byte on bus once turned; advances after strobe sampled low
// - rx_data_avail_n high when read data is used up
// - byte taken only when space and write strobe both low
// - async fifo: transfer on strobe falling edges, no clock
// - async fifo: clock held still, bus turn input ignored
// - serial idle: write status on line 0, read status on miso
// - control bit switches idle status driving off
// - select active: command phase first, then data while selected
// - ack or nak on miso for each data byte
// - command byte captured parallel on first edge after select
// - width by priority: 8, 4, 2, else 1 bit
// - data lines treated as pulled high
// - command code from bits 0,3,5,6; bit 7 ignored
// - 1-bit: command over 7 clocks, 8th clock turnaround
// - 1-bit: each data byte takes eight clocks
// - select active: line 0 released at once
module hfp_host_port
#(
  parameter int FCLK_HALF = hfp_pkg::FCLK_HALF_CYC
)
(
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [hfp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic      [31:0]                prdata,
  // fifo strobes and flags
  input  wire logic                       read_strobe_n,
  input  wire logic                       write_strobe_n,
  input  wire logic                       bus_turn_enable_n,
  output logic                            fifo_clock_out,
  output logic                            rx_data_avail_n,
  output logic                            tx_space_avail_n,
  // serial slave
  input  wire logic                       slave_select_low,
  input  wire logic                       serial_clk,
  output logic                            miso,
  output logic                            miso_oe,
  // shared data lines
  input  wire logic [7:0]                 bidir_data_lines_in,
  output logic      [7:0]                 bidir_data_lines_out,
  output logic      [7:0]                 bidir_data_lines_oe,
  // nonvolatile mode strap
  input  wire logic [1:0]                 nv_mode_strap
);
  import hfp_pkg::*;

  typedef struct packed {
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    hfp_mode_type  req_mode;
    hfp_mode_type  nv_mode;
    hfp_mode_type  mode;
    logic [1:0]    strap_cnt;
    logic          stat_en;
    logic          rx_valid;
    logic [7:0]    rx_byte;
    logic          tx_valid;
    logic [7:0]    tx_byte;
    logic          rx_avail_n;
    logic          tx_space_n;
    logic [7:0]    d_out;
    logic [7:0]    d_oe;
    logic          miso;
    logic          miso_oe;
    logic          rd_prev;
    logic          wr_prev;
    logic          sclk_prev;
    hfp_ser_type   sst;
    hfp_width_type width;
    logic [2:0]    cnt;
    logic [7:0]    cmd;
    logic [7:0]    sh;
    logic          dir_rd;
    logic          ok;
    logic [3:0]    last_cmd;
  } hfp_port_state_type;

  hfp_port_state_type s;
  hfp_port_state_type next_s;
  hfp_pins_type       pins_raw;
  hfp_pins_type       pin;
  logic               fclk;
  logic               frise;

  assign pins_raw = '{rd_n:    read_strobe_n,
                      wr_n:    write_strobe_n,
                      oe_n:    bus_turn_enable_n,
                      ss_low:  slave_select_low,
                      sclk:    serial_clk,
                      nv_mode: nv_mode_strap,
                      data:    bidir_data_lines_in};

  hfp_sync #(.W($bits(hfp_pins_type))) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pins_raw),
    .q       (pin)
  );

  // clock runs only in sync fifo mode
  hfp_clkdiv #(.HALF(FCLK_HALF)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (s.mode == MODE_SYNC),
    .clk_out (fclk),
    .rise    (frise)
  );

  // start of a serial data byte: claim buffer and set ack
  function automatic hfp_port_state_type ser_start(
    input hfp_port_state_type st);
    hfp_port_state_type r;
    logic [7:0]         m;
    r     = st;
    m     = width_mask(st.width);
    r.cnt = '0;
    r.sh  = '0;
    if (st.dir_rd)
    begin
      r.ok = st.rx_valid;
      if (st.rx_valid)
      begin
        r.sh       = st.rx_byte;
        r.rx_valid = 1'b0;
      end
      r.d_out = r.sh & m;
      r.d_oe  = m;
    end
    else
    begin
      r.ok   = (st.last_cmd == CMD_WRITE) && !st.tx_valid;
      r.d_oe = '0;
    end
    r.miso = r.ok ? ACK_LEVEL : NAK_LEVEL;
    return r;
  endfunction

  logic [3:0] beats_last;
  logic [7:0] mask;
  logic [3:0] wbits;
  logic       sclk_rise;
  logic       apb_acc;

  always_comb
  begin
    next_s     = s;
    mask       = width_mask(s.width);
    wbits      = 4'h1 << s.width;
    beats_last = (4'h8 >> s.width) - 4'h1;
    sclk_rise  = pin.sclk & ~s.sclk_prev;
    apb_acc    = psel & penable;
    next_s.rd_prev   = pin.rd_n;
    next_s.wr_prev   = pin.wr_n;
    next_s.sclk_prev = pin.sclk;

    // strap caught once the synchroniser has settled
    if (s.strap_cnt != 2'(SYNC_STAGES + 1))
    begin
      next_s.strap_cnt = s.strap_cnt + 2'h1;
      next_s.nv_mode   = hfp_mode_type'(pin.nv_mode);
    end
    if (s.req_mode == MODE_SYNC && s.nv_mode != MODE_ASYNC)
      next_s.mode = s.nv_mode;
    else
      next_s.mode = s.req_mode;

    // apb: one wait state, effects at the completing edge
    next_s.pslverr = 1'b0;
    if (apb_acc && !s.pready)
    begin
      next_s.pready  = 1'b1;
      next_s.pslverr = 1'b0;
      next_s.prdata  = '0;
      case (paddr)
        ADDR_CTRL:
        begin
          next_s.prdata[CTRL_MODE_LSB +: 2] = s.req_mode;
          next_s.prdata[CTRL_STAT_EN]       = s.stat_en;
        end
        ADDR_STATUS:
        begin
          next_s.prdata[ST_MODE_LSB +: 2]  = s.mode;
          next_s.prdata[ST_RX_VALID]       = s.rx_valid;
          next_s.prdata[ST_TX_VALID]       = s.tx_valid;
          next_s.prdata[ST_WIDTH_LSB +: 2] = s.width;
          next_s.prdata[ST_SER_LSB +: 2]   = s.sst;
          next_s.prdata[ST_CMD_LSB +: 4]   = s.last_cmd;
        end
        ADDR_RXDATA:
        begin
          // refused write answers with zero data
          next_s.pslverr = pwrite & s.rx_valid;
          if (!next_s.pslverr)
            next_s.prdata[BYTE_W-1:0] = s.rx_byte;
        end
        ADDR_TXDATA:
          next_s.prdata[BYTE_W-1:0] = s.tx_byte;
        default:
          next_s.pslverr = 1'b1;
      endcase
    end
    else if (apb_acc && s.pready)
    begin
      next_s.pready = 1'b0;
      if (pwrite && !s.pslverr)
      begin
        case (paddr)
          ADDR_CTRL:
          begin
            next_s.req_mode = hfp_mode_type'(pwdata[CTRL_MODE_LSB +: 2]);
            next_s.stat_en  = pwdata[CTRL_STAT_EN];
          end
          ADDR_RXDATA:
          begin
            next_s.rx_byte  = pwdata[BYTE_W-1:0];
            next_s.rx_valid = 1'b1;
          end
          default:
            next_s.rx_valid = next_s.rx_valid;
        endcase
      end
      else if (!pwrite && paddr == ADDR_TXDATA)
        next_s.tx_valid = 1'b0;
    end
    else
      next_s.pready = 1'b0;

    // port logic runs after apb so hardware sets win
    case (s.mode)
      MODE_ASYNC:
      begin
        next_s.sst     = SER_IDLE;
        next_s.miso_oe = 1'b0;
        if (!pin.rd_n && s.rd_prev && s.rx_valid)
        begin
          next_s.d_out    = s.rx_byte;
          next_s.rx_valid = 1'b0;
        end
        next_s.d_oe = pin.rd_n ? 8'h00 : 8'hff;
        if (!pin.wr_n && s.wr_prev && !s.tx_valid)
        begin
          next_s.tx_byte  = pin.data;
          next_s.tx_valid = 1'b1;
        end
        next_s.rx_avail_n = ~next_s.rx_valid;
        next_s.tx_space_n = next_s.tx_valid;
      end
      MODE_SYNC:
      begin
        next_s.sst     = SER_IDLE;
        next_s.miso_oe = 1'b0;
        if (frise)
        begin
          if (!s.rx_avail_n && !pin.oe_n && !pin.rd_n)
            next_s.rx_valid = 1'b0;
          if (!s.tx_space_n && !pin.wr_n && pin.oe_n)
          begin
            next_s.tx_byte  = pin.data;
            next_s.tx_valid = 1'b1;
          end
          next_s.rx_avail_n = ~next_s.rx_valid;
          next_s.tx_space_n = next_s.tx_valid;
          next_s.d_out      = next_s.rx_byte;
          next_s.d_oe       = pin.oe_n ? 8'h00 : 8'hff;
        end
      end
      MODE_SERIAL:
      begin
        next_s.rx_avail_n = 1'b1;
        next_s.tx_space_n = 1'b1;
        if (pin.ss_low)
        begin
          next_s.sst     = SER_IDLE;
          next_s.d_oe    = {7'h00, s.stat_en};
          next_s.d_out   = {7'h00, s.tx_valid};
          next_s.miso    = ~s.rx_valid;
          next_s.miso_oe = s.stat_en;
        end
        else
        begin
          next_s.miso_oe = 1'b1;
          case (s.sst)
            SER_IDLE:
            begin
              next_s.d_oe = 8'h00;
              if (sclk_rise)
              begin
                next_s.cmd   = pin.data;
                next_s.width = decode_width(pin.data);
                next_s.cnt   = 3'h1;
                if (decode_width(pin.data) == WIDTH_1)
                  next_s.sst = SER_CMD;
                else
                  next_s.sst = SER_TURN;
              end
            end
            SER_CMD:
              if (sclk_rise)
              begin
                next_s.cmd[s.cnt] = pin.data[0];
                next_s.cnt        = s.cnt + 3'h1;
                if (s.cnt == CMD_LAST_BIT)
                  next_s.sst = SER_TURN;
              end
            SER_TURN:
              if (sclk_rise)
              begin
                next_s.last_cmd = decode_cmd(s.cmd);
                next_s.dir_rd   = decode_cmd(s.cmd) == CMD_READ;
                next_s.sst      = SER_DATA;
                next_s          = ser_start(next_s);
              end
            SER_DATA:
              if (sclk_rise)
              begin
                next_s.cnt = s.cnt + 3'h1;
                if (s.dir_rd)
                  next_s.sh = s.sh >> wbits;
                else
                  next_s.sh = (s.sh >> wbits) |
                              ((pin.data & mask) << (4'h8 - wbits));
                next_s.d_out = next_s.sh & mask;
                if ({1'b0, s.cnt} == beats_last)
                begin
                  if (!s.dir_rd && s.ok)
                  begin
                    next_s.tx_byte  = next_s.sh;
                    next_s.tx_valid = 1'b1;
                  end
                  next_s = ser_start(next_s);
                end
              end
            default:
              next_s.sst = SER_IDLE;
          endcase
        end
      end
      default:
      begin
        next_s.sst        = SER_IDLE;
        next_s.d_oe       = 8'h00;
        next_s.miso_oe    = 1'b0;
        next_s.rx_avail_n = 1'b1;
        next_s.tx_space_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s            <= '0;
      s.req_mode   <= CTRL_MODE_RESET;
      s.nv_mode    <= MODE_ASYNC;
      s.mode       <= CTRL_MODE_RESET;
      s.stat_en    <= STAT_EN_RESET;
      s.rx_avail_n <= 1'b1;
      s.tx_space_n <= 1'b1;
      s.miso       <= NAK_LEVEL;
      s.rd_prev    <= 1'b1;
      s.wr_prev    <= 1'b1;
      s.sclk_prev  <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign pready               = s.pready;
  assign pslverr              = s.pslverr;
  assign prdata               = s.prdata;
  assign fifo_clock_out       = fclk;
  assign rx_data_avail_n      = s.rx_avail_n;
  assign tx_space_avail_n     = s.tx_space_n;
  assign miso                 = s.miso;
  assign miso_oe              = s.miso_oe;
  assign bidir_data_lines_out = s.d_out;
  assign bidir_data_lines_oe  = s.d_oe;
endmodule
`default_nettype wire

//--- tb/hfp_host_port_asserts.sv
// concurrent checks on the host fifo port pins and apb answers
`timescale 1ns/100ps
`default_nettype none
module hfp_host_port_asserts
#(
  parameter int FCLK_HALF = 3
)
(
  // clock, reset, apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // fifo and serial pins
  input wire logic        fifo_clock_out,
  input wire logic        rx_data_avail_n,
  input wire logic        bus_turn_enable_n,
  input wire logic        slave_select_low,
  input wire logic        miso_oe,
  input wire logic [7:0]  bidir_data_lines_oe
);
  int hi_cnt;
  // length of the running high phase of the interface clock
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hi_cnt <= 0;
    else
      hi_cnt <= fifo_clock_out ? hi_cnt + 1 : 0;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_pready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_access: assert property (
    pready |-> psel && penable && $past(penable))
    else $error("pready outside an access phase");
  a_err_zero: assert property (
    pslverr |-> pready && prdata == 32'h0)
    else $error("refused access without pready or with data");
  a_clk_high: assert property (
    $fell(fifo_clock_out) |-> hi_cnt == FCLK_HALF)
    else $error("interface clock high phase wrong");
  a_clk_low: assert property (
    $fell(fifo_clock_out) |-> !fifo_clock_out [*3])
    else $error("interface clock low phase too short");
  a_sel_release: assert property (
    $fell(slave_select_low) |-> ##4 bidir_data_lines_oe == 8'h00)
    else $error("data lines still driven after select");
  a_turn_release: assert property (
    bus_turn_enable_n [*8] ##0 (fifo_clock_out && $past(fifo_clock_out))
    |-> bidir_data_lines_oe == 8'h00)
    else $error("data lines driven while bus not turned");
  a_reset_idle: assert property (
    $rose(presetn) |-> rx_data_avail_n && !miso_oe && !fifo_clock_out
    && bidir_data_lines_oe == 8'h00)
    else $error("outputs not idle after reset");
endmodule
bind hfp_host_port hfp_host_port_asserts #(.FCLK_HALF(FCLK_HALF))
  u_hfp_host_port_asserts (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .prdata, .fifo_clock_out, .rx_data_avail_n, .bus_turn_enable_n,
  .slave_select_low, .miso_oe, .bidir_data_lines_oe);
`default_nettype wire

//--- tb/hfp_master_model.sv
// far-side master model driving fifo strobes, serial pins and data lines
`timescale 1ns/100ps
`default_nettype none
module hfp_master_model
(
  // clock
  input  wire logic       pclk,
  // strobes and serial pins
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic            bus_turn_enable_n,
  output logic            slave_select_low,
  output logic            serial_clk,
  input  wire logic       miso,
  // shared lines
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe,
  output logic      [7:0] lines_in
);
  logic [7:0] m_out = 8'h00;
  logic [7:0] m_oe = 8'h00;
  // undriven lines float up
  assign lines_in = (dev_oe & dev_out) | (~dev_oe & (m_out | ~m_oe));
  initial
  begin
    {read_strobe_n, write_strobe_n, bus_turn_enable_n} = 3'h7;
    slave_select_low = 1'b1;
    serial_clk = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic strobe_read(input logic sync, output logic [7:0] d);
    if (sync)
    begin
      bus_turn_enable_n <= 1'b0;
      wait_n(16);
      d = lines_in;
    end
    read_strobe_n <= 1'b0;
    wait_n(16);
    if (!sync)
      d = lines_in;
    read_strobe_n <= 1'b1;
    bus_turn_enable_n <= 1'b1;
    wait_n(8);
  endtask
  // only called while space is shown
  task automatic strobe_write(input logic [7:0] d);
    m_out <= d;
    m_oe <= 8'hff;
    wait_n(4);
    write_strobe_n <= 1'b0;
    wait_n(16);
    write_strobe_n <= 1'b1;
    wait_n(4);
    m_oe <= 8'h00;
    wait_n(4);
  endtask
  // frame: command edges, turnaround edge, one edge per byte
  task automatic frame(input logic [7:0] cmd, input int n, input logic rd,
                       input logic [7:0] d, output logic ack,
                       output logic [7:0] got);
    int t;
    // 1-bit width: command bits 1..6 on line 0, turn on the 8th edge
    t = (cmd[7:1] == 7'h7f) ? 7 : 1;
    slave_select_low <= 1'b0;
    wait_n(4);
    for (int k = 0; k < n; k++)
    begin
      m_oe <= (k == t || (k > t && rd)) ? 8'h00 : 8'hff;
      m_out <= (k == 0) ? cmd : (k < t) ? {7'h00, cmd[k]} : d;
      wait_n(4);
      if (k == t + 1)
      begin
        ack = miso;
        got = lines_in;
        if (ack)
          break;
      end
      serial_clk <= 1'b1;
      wait_n(4);
      serial_clk <= 1'b0;
    end
    m_oe <= 8'h00;
    wait_n(4);
    slave_select_low <= 1'b1;
    wait_n(8);
  endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the host fifo port
`timescale 1ns/100ps
`default_nettype none
module tb;
  import hfp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic read_strobe_n, write_strobe_n, bus_turn_enable_n, fifo_clock_out;
  logic rx_data_avail_n, tx_space_avail_n, slave_select_low, serial_clk;
  logic miso, miso_oe;
  logic [7:0] bidir_data_lines_in, bidir_data_lines_out;
  logic [7:0] bidir_data_lines_oe, d;
  logic [1:0] nv_mode_strap = 2'h0;
  logic [7:0] cmds [6] = '{8'hff, 8'hfd, 8'hfb, 8'hef, 8'h7e, 8'hf1};
  int failures = 0;
  int n_compared = 0;
  hfp_host_port #(.FCLK_HALF(3)) u_hfp_host_port (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .read_strobe_n, .write_strobe_n, .bus_turn_enable_n, .fifo_clock_out,
    .rx_data_avail_n, .tx_space_avail_n, .slave_select_low, .serial_clk,
    .miso, .miso_oe, .bidir_data_lines_in, .bidir_data_lines_out,
    .bidir_data_lines_oe, .nv_mode_strap);
  hfp_master_model u_hfp_master_model (.pclk, .read_strobe_n,
    .write_strobe_n, .bus_turn_enable_n, .slave_select_low, .serial_clk,
    .miso, .dev_out(bidir_data_lines_out), .dev_oe(bidir_data_lines_oe),
    .lines_in(bidir_data_lines_in));
  always #10 pclk = ~pclk;
  task automatic complete_run;
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdv);
  endtask
  // width code by priority, unused lines read high
  function automatic logic [1:0] exp_w(input logic [7:0] b);
    if (b[7:4] != 4'hf)
      return 2'h3;
    if (b[3:2] != 2'h3)
      return 2'h2;
    return b[1] ? 2'h0 : 2'h1;
  endfunction
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    complete_run;
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_CTRL, 32'h4, "ctrl reset");
    rdc(ADDR_STATUS, 32'h0, "status reset");
    rdc(12'h010, 32'h0, "unmapped data");
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b1, ADDR_RXDATA, 32'ha5);
    apb(1'b1, ADDR_RXDATA, 32'h5a);
    chk("rx full err", 32'h1, {31'h0, er});
    repeat (8) @(posedge pclk);
    chk("rx avail", 32'h0, {31'h0, rx_data_avail_n});
    u_hfp_master_model.strobe_read(1'b0, d);
    chk("async read", 32'ha5, {24'h0, d});
    chk("rx drained", 32'h1, {31'h0, rx_data_avail_n});
    u_hfp_master_model.strobe_write(8'h3c);
    chk("tx full", 32'h1, {31'h0, tx_space_avail_n});
    rdc(ADDR_TXDATA, 32'h3c, "async write");
    apb(1'b1, ADDR_CTRL, 32'h6);
    repeat (8) @(posedge pclk);
    chk("idle line0", 32'h0, {31'h0, bidir_data_lines_in[0]});
    chk("idle miso", 32'h1, {31'h0, miso});
    foreach (cmds[i])
    begin
      u_hfp_master_model.frame(cmds[i], (exp_w(cmds[i]) == 2'h0) ? 8 : 2,
                               1'b0, 8'h0, ack, d);
      rdc(ADDR_STATUS, {20'h0, cmds[i][0], cmds[i][3], cmds[i][5],
          cmds[i][6], 2'h0, exp_w(cmds[i]), 4'h2}, "decode");
    end
    u_hfp_master_model.frame(8'h00, 3, 1'b0, 8'hc3, ack, d);
    chk("write ack", 32'h0, {31'h0, ack});
    u_hfp_master_model.frame(8'h00, 3, 1'b0, 8'h3c, ack, d);
    chk("write nak", 32'h1, {31'h0, ack});
    rdc(ADDR_TXDATA, 32'hc3, "serial write");
    apb(1'b1, ADDR_RXDATA, 32'h99);
    repeat (8) @(posedge pclk);
    chk("idle miso full", 32'h0, {31'h0, miso});
    u_hfp_master_model.frame(8'h40, 3, 1'b1, 8'h0, ack, d);
    chk("read ack", 32'h0, {31'h0, ack});
    chk("serial read", 32'h99, {24'h0, d});
    apb(1'b1, ADDR_CTRL, 32'h2);
    repeat (8) @(posedge pclk);
    chk("status hidden", 32'h0, {23'h0, miso_oe, bidir_data_lines_oe});
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_RXDATA, 32'h81);
    repeat (16) @(posedge pclk);
    u_hfp_master_model.strobe_read(1'b1, d);
    chk("sync read", 32'h81, {24'h0, d});
    chk("sync drained", 32'h1, {31'h0, rx_data_avail_n});
    u_hfp_master_model.strobe_write(8'h42);
    chk("sync tx full", 32'h1, {31'h0, tx_space_avail_n});
    rdc(ADDR_TXDATA, 32'h42, "sync write");
    nv_mode_strap <= 2'h2;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h5);
    rdc(ADDR_STATUS, 32'h2, "strap blocks sync");
    complete_run;
  end
endmodule
`default_nettype wire
